// ### logic/spi_cmd_pkg.sv
package spi_cmd_pkg;

	// ==========================================================
	// Framing
	// ==========================================================
	localparam int          BYTE_BITS      = 8;
	localparam int          OUT_BYTES      = 5;
	localparam logic [7:0]  READ_OUT_ADDR  = 8'h26;
	localparam logic [7:0]  RESET_OUT_BYTE = 8'h00;
	localparam logic [39:0] RESET_RESULT   = 40'h00_0000_0000;

	// ==========================================================
	// Clock and timing
	// ==========================================================
	localparam int CLK_HZ           = 10_000_000;
	localparam int BUSY_FREQ_US     = 250;
	localparam int BUSY_POWER_US    = 350;
	localparam int BUSY_MIN_US      = 50;
	localparam int BUSY_MAX_US      = 600;
	localparam int BUSY_FREQ_CYC    = BUSY_FREQ_US * (CLK_HZ / 1_000_000);
	localparam int BUSY_POWER_CYC   = BUSY_POWER_US * (CLK_HZ / 1_000_000);
	localparam int BUSY_MIN_CYC     = (BUSY_MIN_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int BUSY_MAX_CYC     = BUSY_MAX_US * (CLK_HZ / 1_000_000);
	localparam int BUSY_CNT_W       = 16;

	// ==========================================================
	// Command classes
	// ==========================================================
	localparam logic [7:0] ADDR_FREQ  = 8'h10;
	localparam logic [7:0] ADDR_POWER = 8'h14;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BUSY
	} proc_state_t;

endpackage : spi_cmd_pkg

// ### logic/spi_command_slave_port.sv
`timescale 1ns/1ps
module spi_command_slave_port #(
	parameter int BUSY_FREQ  = spi_cmd_pkg::BUSY_FREQ_CYC,
	parameter int BUSY_POWER = spi_cmd_pkg::BUSY_POWER_CYC,
	parameter int BUSY_OTHER = spi_cmd_pkg::BUSY_MIN_CYC,
	parameter int BUSY_MAX   = spi_cmd_pkg::BUSY_MAX_CYC
) (
	// System
	input  wire logic        mclk,
	input  wire logic        reset,
	// Serial link
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	output logic             miso,
	output logic             command_ready_out,
	// Strap
	input  wire logic        mode_strap,
	// Command output to the core
	output logic             cmd_valid,
	output logic [7:0]       cmd_addr,
	output logic [39:0]      cmd_data,
	output logic [2:0]       cmd_len,
	// Query result from the core
	input  wire logic        result_load,
	input  wire logic [39:0] result_data
);

	// ==========================================================
	// Strap capture and mode
	// ==========================================================
	logic strap_s1_ff;
	logic strap_s2_ff;
	logic strap_done_ff;
	logic mode1_ff;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			strap_s1_ff <= 1'b1;
			strap_s2_ff <= 1'b1;
		end else begin
			strap_s1_ff <= mode_strap;
			strap_s2_ff <= strap_s1_ff;
		end
	end

	// The strap is latched once, three edges after the reset release.
	logic [1:0] strap_wait_ff;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			strap_wait_ff <= 2'h0;
			strap_done_ff <= 1'b0;
			mode1_ff      <= 1'b1;
		end else if (!strap_done_ff) begin
			strap_wait_ff <= strap_wait_ff + 2'h1;
			if (strap_wait_ff == 2'h2) begin
				strap_done_ff <= 1'b1;
				mode1_ff      <= strap_s2_ff;
			end
		end
	end

	// Mode bit is steady long before any frame, so the link side reads it directly.
	logic sck_eff;
	assign sck_eff = mode1_ff ? ~sclk : sclk;

	// ==========================================================
	// Link domain: shifter
	// ==========================================================
	logic [2:0] bit_cnt_ff;
	logic [6:0] shift_in_ff;
	logic [7:0] rx_byte_ff;
	logic       rx_tog_ff;
	logic [7:0] tx_byte_ff;
	logic [2:0] tx_bit_ff;
	logic [7:0] tx_src;

	// Bit counter and input shifter are held clear while select is high.
	always_ff @(posedge sck_eff or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_ff  <= 3'h0;
			shift_in_ff <= 7'h00;
		end else begin
			bit_cnt_ff  <= bit_cnt_ff + 3'h1;
			shift_in_ff <= {shift_in_ff[5:0], mosi};
		end
	end

	always_ff @(posedge sck_eff or posedge reset) begin
		if (reset) begin
			rx_byte_ff <= 8'h00;
			rx_tog_ff  <= 1'b0;
		end else if (!cs_n && bit_cnt_ff == 3'h7) begin
			rx_byte_ff <= {shift_in_ff, mosi};
			rx_tog_ff  <= ~rx_tog_ff;
		end
	end

	// Output changes on the opposite edge so the host samples it settled.
	always_ff @(negedge sck_eff or posedge cs_n) begin
		if (cs_n) begin
			tx_bit_ff <= 3'h7;
		end else begin
			tx_bit_ff <= tx_bit_ff - 3'h1;
		end
	end

	always_ff @(negedge sck_eff or posedge reset) begin
		if (reset) begin
			tx_byte_ff <= 8'h00;
		end else if (tx_bit_ff == 3'h7) begin
			tx_byte_ff <= tx_src;
		end
	end

	assign miso = (tx_bit_ff == 3'h7) ? tx_src[7] : tx_byte_ff[tx_bit_ff];

	// ==========================================================
	// System domain: byte collection
	// ==========================================================
	localparam int BUSY_CNT_W = spi_cmd_pkg::BUSY_CNT_W;

	logic       tog_s1_ff;
	logic       tog_s2_ff;
	logic       tog_s3_ff;
	logic       byte_evt;
	logic [2:0] got_ff;
	logic [2:0] need_ff;
	logic [7:0] addr_ff;
	logic [39:0] data_ff;
	logic        busy_ff;
	logic [39:0] result_ff;
	logic [2:0]  out_idx_ff;
	logic [BUSY_CNT_W-1:0] busy_cnt_ff;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tog_s1_ff <= 1'b0;
			tog_s2_ff <= 1'b0;
			tog_s3_ff <= 1'b0;
		end else begin
			tog_s1_ff <= rx_tog_ff;
			tog_s2_ff <= tog_s1_ff;
			tog_s3_ff <= tog_s2_ff;
		end
	end
	assign byte_evt = (tog_s2_ff ^ tog_s3_ff) && !busy_ff;

	// Data byte count by register; unknown addresses take one.
	function automatic logic [2:0] data_count(input logic [7:0] a);
		unique case (a)
			8'h06, 8'h07, 8'h08, 8'h0D, spi_cmd_pkg::READ_OUT_ADDR: data_count = 3'h5;
			8'h09, 8'h0A, 8'h0C:                                    data_count = 3'h4;
			spi_cmd_pkg::ADDR_FREQ:                                 data_count = 3'h5;
			spi_cmd_pkg::ADDR_POWER:                                data_count = 3'h2;
			default:                                                data_count = 3'h1;
		endcase
	endfunction : data_count

	function automatic logic [BUSY_CNT_W-1:0] busy_time(input logic [7:0] a);
		int t;
		t = (a == spi_cmd_pkg::ADDR_FREQ)  ? BUSY_FREQ :
		    (a == spi_cmd_pkg::ADDR_POWER) ? BUSY_POWER : BUSY_OTHER;
		if (t > BUSY_MAX) t = BUSY_MAX;
		busy_time = BUSY_CNT_W'(t);
	endfunction : busy_time

	logic done_now;
	assign done_now = byte_evt && got_ff != 3'h0 && got_ff == need_ff;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			got_ff  <= 3'h0;
			need_ff <= 3'h0;
			addr_ff <= 8'h00;
			data_ff <= 40'h00_0000_0000;
		end else if (byte_evt) begin
			if (got_ff == 3'h0) begin
				addr_ff <= rx_byte_ff;
				need_ff <= data_count(rx_byte_ff);
				got_ff  <= 3'h1;
				// Old data is dropped so that short commands come out zero filled.
				data_ff <= 40'h00_0000_0000;
			end else begin
				data_ff <= {data_ff[31:0], rx_byte_ff};
				got_ff  <= done_now ? 3'h0 : got_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			busy_ff     <= 1'b0;
			busy_cnt_ff <= '0;
			cmd_valid   <= 1'b0;
			cmd_addr    <= 8'h00;
			cmd_data    <= 40'h00_0000_0000;
			cmd_len     <= 3'h0;
		end else begin
			cmd_valid <= done_now;
			if (done_now) begin
				busy_ff     <= 1'b1;
				busy_cnt_ff <= busy_time(addr_ff);
				cmd_addr    <= addr_ff;
				cmd_data    <= {data_ff[31:0], rx_byte_ff};
				cmd_len     <= need_ff;
			end else if (busy_ff) begin
				if (busy_cnt_ff <= BUSY_CNT_W'(1)) begin
					busy_ff <= 1'b0;
				end
				busy_cnt_ff <= busy_cnt_ff - BUSY_CNT_W'(1);
			end
		end
	end
	assign command_ready_out = !busy_ff;

	// ==========================================================
	// Result buffer feeding the transmitter
	// ==========================================================
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			result_ff  <= spi_cmd_pkg::RESET_RESULT;
			out_idx_ff <= 3'h0;
		end else begin
			if (result_load) begin
				result_ff <= result_data;
			end
			if (byte_evt && got_ff == 3'h0) begin
				out_idx_ff <= (rx_byte_ff == spi_cmd_pkg::READ_OUT_ADDR) ? 3'h1 : 3'h0;
			end else if (byte_evt && out_idx_ff != 3'h0) begin
				out_idx_ff <= (out_idx_ff == 3'h5) ? 3'h0 : out_idx_ff + 3'h1;
			end
		end
	end

	// Byte k of the result (k from 1) is the (5-k)th byte, so MSB leaves first.
	always_comb begin
		unique case (out_idx_ff)
			3'h1:    tx_src = result_ff[39:32];
			3'h2:    tx_src = result_ff[31:24];
			3'h3:    tx_src = result_ff[23:16];
			3'h4:    tx_src = result_ff[15:8];
			3'h5:    tx_src = result_ff[7:0];
			default: tx_src = spi_cmd_pkg::RESET_OUT_BYTE;
		endcase
	end

endmodule : spi_command_slave_port

// ### bench/spi_cmd_chk.sv
`timescale 1ns/1ps
// ========
// Checker on the command side of the port.
module spi_cmd_chk #(
	parameter int BUSY_FREQ  = 2500,
	parameter int BUSY_POWER = 3500,
	parameter int BUSY_OTHER = 500,
	parameter int BUSY_MAX   = 6000
) (
	// System
	input wire logic       mclk,
	input wire logic       reset,
	// Command side
	input wire logic       command_ready_out,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_addr,
	input wire logic [2:0] cmd_len
);
	int cnt_ff;
	int exp_ff;

	function automatic logic [2:0] len_of(input logic [7:0] a);
		case (a)
			8'h06, 8'h07, 8'h08, 8'h0D, 8'h26, 8'h10: return 3'h5;
			8'h09, 8'h0A, 8'h0C: return 3'h4;
			8'h14: return 3'h2;
			default: return 3'h1;
		endcase
	endfunction : len_of

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) cnt_ff <= 0;
		else if (command_ready_out) cnt_ff <= 0;
		else cnt_ff <= cnt_ff + 1;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) exp_ff <= 0;
		else if (cmd_valid) exp_ff <= (cmd_addr == 8'h10) ? BUSY_FREQ :
			(cmd_addr == 8'h14) ? BUSY_POWER : BUSY_OTHER;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	a_ready_drops: assert property (cmd_valid |-> !command_ready_out)
		else $error("ready high with a new command");
	a_fall_cause: assert property ($fell(command_ready_out) |-> cmd_valid)
		else $error("ready fell without a command");
	a_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
		else $error("command strobe longer than one cycle");
	a_busy_ignore: assert property (cmd_valid |-> $past(command_ready_out))
		else $error("command taken while busy");
	a_busy_time: assert property ($rose(command_ready_out) |-> cnt_ff == exp_ff)
		else $error("busy time wrong for command");
	a_busy_cap: assert property (cnt_ff <= BUSY_MAX)
		else $error("busy time above the cap");
	a_len_table: assert property (cmd_valid |-> cmd_len == len_of(cmd_addr))
		else $error("data count wrong for address");
	a_len_range: assert property (cmd_valid |-> cmd_len inside {[1:5]})
		else $error("data count out of range");
endmodule : spi_cmd_chk

bind spi_command_slave_port spi_cmd_chk #(.BUSY_FREQ(BUSY_FREQ), .BUSY_POWER(BUSY_POWER),
	.BUSY_OTHER(BUSY_OTHER), .BUSY_MAX(BUSY_MAX)) chk (.mclk(mclk), .reset(reset),
	.command_ready_out(command_ready_out), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
	.cmd_len(cmd_len));

// ### bench/spi_host_model.sv
`timescale 1ns/1ps
// ========
// Host that masters the serial link.
module spi_host_model (
	// Link mode
	input  wire logic mode,
	// Serial link
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	logic [7:0] rx_q[$];

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// Sends n bytes, first byte in the top of b, and keeps what came back.
	task automatic frame(input logic [47:0] b, input int n);
		logic [7:0] rx;
		rx_q.delete();
		sclk = mode;
		cs_n = 1'b0;
		#1000;
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) begin
				mosi = b[40 - 8 * i + j];
				#32 rx[j] = miso;
				sclk = !mode;
				#32 sclk = mode;
			end
			rx_q.push_back(rx);
			mosi = !mosi;
			#1000;
		end
		cs_n = 1'b1;
		mosi = !mosi;
	endtask : frame
endmodule : spi_host_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        mclk;
	logic        reset;
	logic        mode_strap;
	logic        result_load;
	logic [39:0] result_data;
	logic        sclk, cs_n, mosi, miso, command_ready_out, cmd_valid;
	logic [7:0]  cmd_addr;
	logic [39:0] cmd_data;
	logic [2:0]  cmd_len;
	int          num_errors = 0;
	int          total_checks = 0;
	int          nvalid, lowc, last_low;

	spi_command_slave_port #(.BUSY_FREQ(40), .BUSY_POWER(30), .BUSY_OTHER(15),
		.BUSY_MAX(50)) dut (.mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .miso(miso), .command_ready_out(command_ready_out),
		.mode_strap(mode_strap), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .cmd_len(cmd_len), .result_load(result_load),
		.result_data(result_data));
	spi_host_model host (.mode(mode_strap), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (cmd_valid === 1'b1) nvalid++;
		if (command_ready_out === 1'b0) lowc++;
		else if (lowc != 0) begin
			last_low = lowc;
			lowc = 0;
		end
	end

	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		total_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict

	task automatic do_reset(input logic strap);
		#1 mode_strap = strap;
		reset = 1'b1;
		repeat (8) @(posedge mclk);
		#1 reset = 1'b0;
		repeat (10) @(posedge mclk);
		#1;
		check(command_ready_out, 1);
	endtask : do_reset

	// Sends a whole command and checks what the core side received.
	task automatic do_cmd(input logic [47:0] b, input int n, input int busy);
		int k = 0;
		nvalid = 0;
		host.frame(b, n);
		check(command_ready_out, 0);
		while (command_ready_out !== 1'b1 && k < 200) begin
			@(posedge mclk);
			#1;
			k++;
		end
		@(posedge mclk);
		#1;
		check(command_ready_out, 1);
		check(nvalid, 1);
		check(cmd_addr, b[47:40]);
		check(cmd_len, n - 1);
		check(cmd_data, b[39:0] >> (8 * (6 - n)));
		check(last_low, busy);
	endtask : do_cmd

	task automatic t_write();
		do_cmd(48'h10_01_02_03_04_05, 6, 40);
		do_cmd(48'h14_A5_5A_00_00_00, 3, 30);
		$display("write test done");
	endtask : t_write

	task automatic t_drop();
		host.frame(48'h10_01_02_03_04_05, 6);
		host.frame(48'h14_00_00_00_00_00, 1);
		do_cmd(48'h01_80_00_00_00_00, 2, 15);
		$display("drop test done");
	endtask : t_drop

	task automatic t_query();
		@(posedge mclk);
		#1 result_data = 40'h11_22_33_44_55;
		result_load = 1'b1;
		@(posedge mclk);
		#1 result_load = 1'b0;
		do_cmd(48'h26_00_00_00_00_00, 6, 15);
		for (int i = 1; i < 6; i++) check(host.rx_q[i], result_data[47 - 8 * i -: 8]);
		$display("query test done");
	endtask : t_query

	task automatic t_hang();
		nvalid = 0;
		host.frame(48'h10_AA_BB_00_00_00, 3);
		repeat (60) @(posedge mclk);
		check(nvalid, 0);
		check(command_ready_out, 1);
		do_reset(1'b0);
		do_cmd(48'h09_01_02_03_04_00, 5, 15);
		$display("hang test done");
	endtask : t_hang

	initial begin
		reset = 1'b1;
		mode_strap = 1'b1;
		result_load = 1'b0;
		result_data = 40'h00_0000_0000;
		do_reset(1'b1);
		t_write();
		t_drop();
		t_query();
		t_hang();
		give_verdict();
	end

	initial begin
		#500000;
		num_errors++;
		give_verdict();
	end
endmodule : tb_top
